// ---- card16_card_model.sv ----
// Card model: read data and optional wait
`timescale 1ns/10ps
`default_nettype none
module card16_card_model (
  // Card pins
  input wire logic clock,
  input wire logic [25:0] card_addr,
  input wire logic card_oe_n,
  input wire logic card_we_n,
  input wire logic card_iord_n,
  input wire logic card_iowr_n,
  input wire logic [15:0] card_data_out,
  output logic [15:0] card_data_in,
  output logic card_wait_n,
  // Bench control
  input wire logic [3:0] stall
);
  logic [15:0] wdat = 16'h0000;
  int n = 0;
  wire logic rd = !(card_oe_n && card_iord_n);
  wire logic [15:0] pat = card_addr[15:0] ^ 16'h5A5A;
  wire logic busy = rd || !card_we_n || !card_iowr_n;
  // Released bus shows the inverse, never a stale value
  assign card_data_in = rd ? pat : ~pat;
  // Wait asserted from strobe start so the synchroniser sees it in time
  assign card_wait_n = !(busy && n < stall);
  always @(posedge clock) begin
    n <= busy ? n + 1 : 0;
    if (!card_we_n || !card_iowr_n) wdat <= card_data_out;
  end
endmodule
`default_nettype wire

// ---- card16_cycle_timing_generator.sv ----
// Card cycle generator with Avalon-MM register access
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Count every phase in bus clocks
// - Lengths from control-register wait-state settings
// - Match legacy timing, never shorter
// - Setup 3 I/O, memory 2 or 4
// - Hold 2 I/O, memory 2 or 3
// - 8-bit strobe 19, 23 or 7
// - 16-bit I/O strobe 7 or 11
// - 16-bit memory strobe 9/13/17/23/5
// - Card wait stretches active strobe
module card16_cycle_timing_generator (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Card side
  output logic [25:0] card_addr,
  output logic card_reg_n,
  output logic card_oe_n,
  output logic card_we_n,
  output logic card_iord_n,
  output logic card_iowr_n,
  output logic [15:0] card_data_out,
  output logic card_data_oe,
  input wire logic [15:0] card_data_in,
  input wire logic card_wait_n
);
  typedef struct packed {
    card16_timing_pkg::phase_t phase;
    logic [4:0] count;
    logic [9:0] ctrl;
    logic [25:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic stretched;
    logic [31:0] readdata;
    logic ack;
    logic [1:0] wait_sync;
    logic [15:0] data_meta;
    logic [15:0] data_sync;
  } state_t;
  state_t state_reg;
  state_t state_next;
  logic [4:0] setup_len;
  logic [4:0] active_len;
  logic [4:0] hold_len;
  logic card_waiting;
  logic strobe;
  logic mem;
  logic wr;
  assign mem = state_reg.ctrl[card16_timing_pkg::CTRL_MEM];
  assign wr = state_reg.ctrl[card16_timing_pkg::CTRL_WRITE];
  assign card_waiting = !state_reg.wait_sync[1];

  card16_phase_table u_table (
    .is_mem(mem),
    .wide(state_reg.ctrl[card16_timing_pkg::CTRL_WIDE]),
    .zero_wait(state_reg.ctrl[card16_timing_pkg::CTRL_ZWS]),
    .wait_state_code(state_reg.ctrl[card16_timing_pkg::CTRL_WS_LO +: 2]),
    .setup_len(setup_len),
    .active_len(active_len),
    .hold_len(hold_len)
  );

  ////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    // Wait pin is asynchronous to the bus clock
    state_next.wait_sync = {state_reg.wait_sync[0], card_wait_n};
    // Data pins too; strobe outlasts the two-flop delay
    state_next.data_meta = card_data_in;
    state_next.data_sync = state_reg.data_meta;
    if ((avs_read || avs_write) && !state_reg.ack) begin
      state_next.ack = 1'b1;
      if (avs_read) begin
        unique case (avs_address)
          card16_timing_pkg::REG_CTRL: state_next.readdata = {22'h0, state_reg.ctrl};
          card16_timing_pkg::REG_ADDR: state_next.readdata = {6'h0, state_reg.addr};
          card16_timing_pkg::REG_DATA: state_next.readdata = {16'h0, state_reg.rdata};
          card16_timing_pkg::REG_STATUS: state_next.readdata =
            {29'h0, state_reg.stretched, state_reg.done, state_reg.phase != card16_timing_pkg::PH_IDLE};
          default: state_next.readdata = 32'h0;
        endcase
      end else if (state_reg.phase == card16_timing_pkg::PH_IDLE) begin
        // Settings frozen while a cycle runs
        unique case (avs_address)
          card16_timing_pkg::REG_CTRL: state_next.ctrl = avs_writedata[9:0];
          card16_timing_pkg::REG_ADDR: state_next.addr = avs_writedata[25:0];
          card16_timing_pkg::REG_DATA: state_next.wdata = avs_writedata[15:0];
          default: ;
        endcase
        if (avs_address == card16_timing_pkg::REG_CTRL && avs_writedata[card16_timing_pkg::CTRL_START]) begin
          state_next.phase = card16_timing_pkg::PH_SETUP;
          state_next.count = 5'h01;
          state_next.done = 1'b0;
          state_next.stretched = 1'b0;
        end
      end
    end
    // Each phase counted in clocks
    unique case (state_reg.phase)
      card16_timing_pkg::PH_IDLE: ;
      card16_timing_pkg::PH_SETUP: begin
        if (state_reg.count >= setup_len) begin
          state_next.phase = card16_timing_pkg::PH_ACTIVE;
          state_next.count = 5'h01;
        end else begin
          state_next.count = state_reg.count + 5'h01;
        end
      end
      card16_timing_pkg::PH_ACTIVE: begin
        if (state_reg.count >= active_len && card_waiting) begin
          state_next.stretched = 1'b1;
        end else if (state_reg.count >= active_len) begin
          state_next.phase = card16_timing_pkg::PH_HOLD;
          state_next.count = 5'h01;
          state_next.rdata = state_reg.data_sync;
        end else begin
          state_next.count = state_reg.count + 5'h01;
        end
      end
      card16_timing_pkg::PH_HOLD: begin
        if (state_reg.count >= hold_len) begin
          state_next.phase = card16_timing_pkg::PH_IDLE;
          state_next.count = 5'h00;
          state_next.done = 1'b1;
        end else begin
          state_next.count = state_reg.count + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '{phase: card16_timing_pkg::PH_IDLE, ctrl: {1'b0, card16_timing_pkg::TS_TABLE, 7'h00},
                     wait_sync: 2'h3, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Strobe only in the active phase
  assign strobe = state_reg.phase == card16_timing_pkg::PH_ACTIVE;
  assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
  assign avs_readdata = state_reg.readdata;
  assign card_addr = state_reg.addr;
  assign card_reg_n = !state_reg.ctrl[card16_timing_pkg::CTRL_REG];
  assign card_oe_n = !(strobe && mem && !wr);
  assign card_we_n = !(strobe && mem && wr);
  assign card_iord_n = !(strobe && !mem && !wr);
  assign card_iowr_n = !(strobe && !mem && wr);
  assign card_data_out = state_reg.wdata;
  assign card_data_oe = wr && state_reg.phase != card16_timing_pkg::PH_IDLE;
endmodule
`default_nettype wire

// ---- card16_cycle_timing_generator_test.sv ----
// Self-checking bench for the card cycle timing generator
`timescale 1ns/10ps
`default_nettype none
module card16_cycle_timing_generator_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, su, ac, ho;
  logic avs_waitrequest, card_reg_n, card_oe_n, card_we_n, card_iord_n, card_iowr_n, card_data_oe, card_wait_n;
  logic [25:0] card_addr;
  logic [15:0] card_data_out, card_data_in;
  logic [3:0] stall = 4'h0;
  logic seen;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  // Entry: ctrl, setup, active, hold
  logic [27:0] tbl [15] = '{28'h0853132, 28'h0A53172, 28'h0953072, 28'h0872132, 28'h0A72172,
    28'h0C74173, 28'h0E74173, 28'h0972072, 28'h08D3072, 28'h0AD30B2, 28'h08F2092, 28'h0AF20D2,
    28'h0CF4113, 28'h0EF4173, 28'h09F2052};
  wire logic act = !(card_oe_n && card_we_n && card_iord_n && card_iowr_n);
  card16_cycle_timing_generator u_card16_cycle_timing_generator (.*);
  card16_card_model u_card16_card_model (.*);
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (act) begin
      ac <= ac + 1;
      seen <= 1'b1;
    end else if (card_data_oe && seen) ho <= ho + 1;
    else if (card_data_oe) su <= su + 1;
    if (++cyc == 6000) begin
      error_cnt++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic start(input logic [11:0] c, output logic [31:0] q);
    {su, ac, ho, seen} <= '0;
    bus(1'b1, 4'h0, {20'h0, c}, q);
    do bus(1'b0, 4'h3, 32'h0, q);
    while (q[0] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h00000080);
    bus(1'b0, 4'h7, 32'h0, q);
    chk(q, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic t_table;
    logic [31:0] q;
    bus(1'b1, 4'h2, 32'h0000C3A5, q);
    for (int i = 0; i < 15; i++) begin
      start(tbl[i][27:16], q);
      chk({29'h0, q[2:0]}, 32'h00000002);
      chk(su, 32'(tbl[i][15:12]));
      chk(ac, 32'(tbl[i][11:4]));
      chk(ho, 32'(tbl[i][3:0]));
    end
    chk({16'h0, u_card16_card_model.wdat}, 32'h0000C3A5);
    $display("table test done");
  endtask
  // Wait stretch plus an address write refused while busy
  task automatic t_wait;
    logic [31:0] q;
    stall <= 4'h6;
    bus(1'b1, 4'h1, 32'h00000100, q);
    {su, ac, ho, seen} <= '0;
    bus(1'b1, 4'h0, 32'h0000009F, q);
    bus(1'b1, 4'h1, 32'h00000200, q);
    do bus(1'b0, 4'h3, 32'h0, q);
    while (q[0] !== 1'b0);
    chk({29'h0, q[2:0]}, 32'h00000006);
    chk({31'h0, ac > 32'h00000008}, 32'h00000001);
    bus(1'b0, 4'h1, 32'h0, q);
    chk(q, 32'h00000100);
    stall <= 4'h0;
    $display("wait test done");
  endtask
  task automatic t_read;
    logic [31:0] q;
    bus(1'b1, 4'h1, 32'h00001234, q);
    start(12'h089, q);
    chk(ac, 32'h00000007);
    bus(1'b0, 4'h2, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h0000486E);
    $display("read test done");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_table();
    t_wait();
    t_read();
    results();
  end
endmodule
`default_nettype wire

// ---- card16_phase_table.sv ----
// Phase length lookup from wait-state settings
`timescale 1ns/10ps
`default_nettype none
module card16_phase_table (
  // Cycle kind
  input wire logic is_mem,
  input wire logic wide,
  input wire logic zero_wait,
  input wire logic [1:0] wait_state_code,
  // Phase lengths
  output logic [4:0] setup_len,
  output logic [4:0] active_len,
  output logic [4:0] hold_len
);
  logic memory_wait_bit_one;
  assign memory_wait_bit_one = wait_state_code[1];
  always_comb begin
    // Never shorter than legacy timing
    if (!is_mem) begin
      setup_len = card16_timing_pkg::SETUP_IO;
      hold_len = card16_timing_pkg::HOLD_IO;
    end else if (memory_wait_bit_one) begin
      setup_len = card16_timing_pkg::SETUP_MEM_SLOW;
      hold_len = card16_timing_pkg::HOLD_MEM_SLOW;
    end else begin
      setup_len = card16_timing_pkg::SETUP_MEM_FAST;
      hold_len = card16_timing_pkg::HOLD_MEM_FAST;
    end
    if (!wide) begin
      // I/O uses only bit zero of the code
      if ((is_mem && wait_state_code != 2'h0) || (!is_mem && wait_state_code[0])) begin
        active_len = card16_timing_pkg::ACT8_WAIT;
      end else if (zero_wait) begin
        active_len = card16_timing_pkg::ACT8_ZWS;
      end else begin
        active_len = card16_timing_pkg::ACT8_NOWAIT;
      end
    end else if (!is_mem) begin
      // Zero-wait has no effect here
      active_len = wait_state_code[0] ? card16_timing_pkg::ACT16_IO_WAIT
                                      : card16_timing_pkg::ACT16_IO_NOWAIT;
    end else begin
      unique case (wait_state_code)
        2'h0: active_len = zero_wait ? card16_timing_pkg::ACT16_MEM_ZWS
                                     : card16_timing_pkg::ACT16_MEM_WS0;
        2'h1: active_len = card16_timing_pkg::ACT16_MEM_WS1;
        2'h2: active_len = card16_timing_pkg::ACT16_MEM_WS2;
        2'h3: active_len = card16_timing_pkg::ACT16_MEM_WS3;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- card16_properties.sv ----
// Checker for the card cycle timing generator
`timescale 1ns/10ps
`default_nettype none
module card16_cycle_checker (
  // Watched ports
  input wire logic clock,
  input wire logic rst,
  input wire logic [25:0] card_addr,
  input wire logic card_reg_n,
  input wire logic card_oe_n,
  input wire logic card_we_n,
  input wire logic card_iord_n,
  input wire logic card_iowr_n,
  input wire logic card_data_oe,
  input wire logic card_wait_n
);
  wire logic act = !(card_oe_n && card_we_n && card_iord_n && card_iowr_n);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_one_strobe: assert property ($countones({card_oe_n, card_we_n, card_iord_n, card_iowr_n}) >= 3)
    else $error("two strobes low");
  a_addr_steady: assert property (act && $past(act) |-> $stable({card_addr, card_reg_n}))
    else $error("address moved in strobe");
  a_min_strobe: assert property ($rose(act) |-> act [*5])
    else $error("strobe too short");
  a_strobe_ends: assert property ($rose(act) ##1 card_wait_n [*8] |-> ##[1:20] !act)
    else $error("strobe too long");
  a_setup_io: assert property ($rose(act) && !card_iowr_n |-> $past(card_data_oe, 3))
    else $error("short io setup");
  a_setup_mem: assert property ($rose(act) && !card_we_n |-> $past(card_data_oe, 2))
    else $error("short mem setup");
  a_hold_min: assert property ($fell(act) && card_data_oe |-> (card_data_oe && $stable(card_addr)) [*2])
    else $error("short hold");
  a_wait_stretch: assert property ((act && !card_wait_n) [*4] |=> act)
    else $error("wait ignored");
  cover property ($rose(act) && !card_iowr_n);
  cover property ($rose(act) && !card_we_n);
  cover property ((act && !card_wait_n) [*4]);
endmodule
bind card16_cycle_timing_generator card16_cycle_checker u_card16_cycle_checker (.*);
`default_nettype wire

// ---- card16_timing_pkg.sv ----
// Constants for the 16-bit card cycle timing generator
package card16_timing_pkg;
  // Phase lengths in bus clocks, timing-select 01
  localparam logic [4:0] SETUP_IO = 5'h03;
  localparam logic [4:0] SETUP_MEM_FAST = 5'h02;
  localparam logic [4:0] SETUP_MEM_SLOW = 5'h04;
  localparam logic [4:0] HOLD_IO = 5'h02;
  localparam logic [4:0] HOLD_MEM_FAST = 5'h02;
  localparam logic [4:0] HOLD_MEM_SLOW = 5'h03;
  localparam logic [4:0] ACT8_NOWAIT = 5'h13;
  localparam logic [4:0] ACT8_WAIT = 5'h17;
  localparam logic [4:0] ACT8_ZWS = 5'h07;
  localparam logic [4:0] ACT16_IO_NOWAIT = 5'h07;
  localparam logic [4:0] ACT16_IO_WAIT = 5'h0B;
  localparam logic [4:0] ACT16_MEM_WS0 = 5'h09;
  localparam logic [4:0] ACT16_MEM_WS1 = 5'h0D;
  localparam logic [4:0] ACT16_MEM_WS2 = 5'h11;
  localparam logic [4:0] ACT16_MEM_WS3 = 5'h17;
  localparam logic [4:0] ACT16_MEM_ZWS = 5'h05;
  localparam logic [1:0] TS_TABLE = 2'h1;
  // Avalon register offsets (word index = byte address / 4)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MEM = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_WIDE = 3;
  localparam int CTRL_ZWS = 4;
  localparam int CTRL_WS_LO = 5;
  localparam int CTRL_TS_LO = 7;
  localparam int CTRL_REG = 9;
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACTIVE, PH_HOLD} phase_t;
endpackage
